// file: lap_pkg.sv
package lap_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int BANK_W   = 3;
  localparam int ROW_W    = 14;
  localparam int COL_W    = 10;
  localparam int DATA_W   = 32;
  localparam int NBANK    = 8;
  localparam int QDEPTH   = 4;
  localparam int QPTR_W   = 2;
  localparam int POOL_N   = 4;
  localparam int POOL_W   = 2;

  // ----------------------------------------------------------------
  // burst shape: eight beats, two per cycle, four cycles
  // ----------------------------------------------------------------
  localparam int          BURST_BEATS  = 8;
  localparam int          BEATS_PER_CY = 2;
  localparam logic [2:0]  BURST_CYCLES = 3'(BURST_BEATS / BEATS_PER_CY);
  localparam logic [2:0]  CNT_RESET    = 3'h0;
  localparam logic [QPTR_W:0] QCNT_RESET = '0;

  // ----------------------------------------------------------------
  // memory command codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MC_NOP   = 3'b000,
    MC_ACT   = 3'b001,
    MC_PRE   = 3'b010,
    MC_WRITE = 3'b011,
    MC_READ  = 3'b100
  } mem_cmd_t;

  typedef struct packed {
    logic              is_write;
    logic              auto_close_flag;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
  } user_req_t;

  typedef struct packed {
    mem_cmd_t          cmd;
    logic              auto_close_flag;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
  } mem_bus_t;

  localparam mem_bus_t MEM_IDLE = '{cmd: MC_NOP, default: '0};

endpackage

// file: lookahead_autoprecharge_ctrl.sv
`timescale 1ns/100ps

// Operation
// - without look-ahead, row change gets explicit precharge then activate
// - with look-ahead, queued commands decide auto-close form per access
// - after auto-close access, same bank new row needs only activate
// - write gets auto-close when a later queued write hits other row
// - read taken when ready high; user holds request until ready
// - bank closed by auto-close: activate then read, no precharge
// - user auto-close input honoured when user control is enabled
// - full tracking pool drops one tracked page for incoming command
module lookahead_autoprecharge_ctrl (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  input  wire logic                    lookahead_en_i,
  input  wire logic                    user_close_en_i,
  input  wire logic                    req_valid_i,
  input  wire lap_pkg::user_req_t      req_i,
  output logic                         req_ready_o,
  output lap_pkg::mem_bus_t            mem_o,
  output logic                         wdata_slot_o,
  output logic [2:0]                   wdata_beat_pair_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic row_change(input lap_pkg::user_req_t a,
                                      input lap_pkg::user_req_t b);
    row_change = (a.bank == b.bank) && (a.row != b.row);
  endfunction

  // ----------------------------------------------------------------
  // command queue
  // ----------------------------------------------------------------
  lap_pkg::user_req_t              q [lap_pkg::QDEPTH];
  lap_pkg::user_req_t              next_q [lap_pkg::QDEPTH];
  logic [lap_pkg::QPTR_W:0]        qcnt;
  logic [lap_pkg::QPTR_W:0]        next_qcnt;

  // ----------------------------------------------------------------
  // page tracking pool
  // ----------------------------------------------------------------
  logic [lap_pkg::POOL_N-1:0]      pv;
  logic [lap_pkg::BANK_W-1:0]      pbank [lap_pkg::POOL_N];
  logic [lap_pkg::ROW_W-1:0]       prow  [lap_pkg::POOL_N];
  logic [lap_pkg::POOL_W-1:0]      victim;
  logic [lap_pkg::POOL_N-1:0]      next_pv;
  logic [lap_pkg::BANK_W-1:0]      next_pbank [lap_pkg::POOL_N];
  logic [lap_pkg::ROW_W-1:0]       next_prow  [lap_pkg::POOL_N];
  logic [lap_pkg::POOL_W-1:0]      next_victim;

  // ----------------------------------------------------------------
  // scheduler
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PRE  = 2'b01,
    S_ACT  = 2'b10,
    S_CAS  = 2'b11
  } sched_t;

  sched_t                          st;
  sched_t                          next_st;
  logic [2:0]                      dcnt;
  logic [2:0]                      next_dcnt;
  lap_pkg::mem_bus_t               next_mem;
  logic                            next_slot;
  logic [2:0]                      next_pair;
  logic                            next_ready;

  logic                            head_hit;
  logic                            head_miss;
  logic [lap_pkg::POOL_W-1:0]      hit_idx;
  logic [lap_pkg::POOL_W-1:0]      free_idx;
  logic                            have_free;
  logic                            head_close;
  logic                            pop;
  logic                            push;

  always_comb begin
    head_hit  = 1'b0;
    head_miss = 1'b0;
    hit_idx   = '0;
    free_idx  = victim;
    have_free = 1'b0;
    for (int i = 0; i < lap_pkg::POOL_N; i++) begin
      if (pv[i] && pbank[i] == q[0].bank) begin
        if (prow[i] == q[0].row) begin
          head_hit = 1'b1;
        end else begin
          head_miss = 1'b1;
        end
        hit_idx = lap_pkg::POOL_W'(i);
      end
    end
    for (int i = lap_pkg::POOL_N - 1; i >= 0; i--) begin
      if (!pv[i]) begin
        free_idx  = lap_pkg::POOL_W'(i);
        have_free = 1'b1;
      end
    end
  end

  // decide auto-close form for the head access
  always_comb begin
    head_close = 1'b0;
    if (user_close_en_i && q[0].auto_close_flag) begin
      head_close = 1'b1;
    end
    if (lookahead_en_i) begin
      for (int i = 1; i < lap_pkg::QDEPTH; i++) begin
        if (lap_pkg::QPTR_W'(i) < qcnt[lap_pkg::QPTR_W-1:0] ||
            qcnt[lap_pkg::QPTR_W]) begin
          if (row_change(q[0], q[i]) &&
              q[0].is_write == q[i].is_write) begin
            head_close = 1'b1;
          end
        end
      end
    end
  end

  always_comb begin
    next_st    = st;
    next_dcnt  = (dcnt != lap_pkg::CNT_RESET) ? dcnt - 3'h1 : dcnt;
    next_mem   = lap_pkg::MEM_IDLE;
    next_slot  = (dcnt != lap_pkg::CNT_RESET);
    next_pair  = lap_pkg::BURST_CYCLES - dcnt;
    next_pv    = pv;
    next_pbank = pbank;
    next_prow  = prow;
    next_victim = victim;
    pop        = 1'b0;
    next_mem.bank = q[0].bank;
    next_mem.row  = q[0].row;
    next_mem.col  = q[0].col;
    unique case (st)
      S_IDLE: begin
        if (qcnt != lap_pkg::QCNT_RESET) begin
          if (head_hit) begin
            next_st = S_CAS;
          end else if (head_miss) begin
            next_st = S_PRE;
          end else if (!have_free) begin
            next_st = S_PRE;
          end else begin
            next_st = S_ACT;
          end
        end
      end
      S_PRE: begin
        next_mem.cmd = lap_pkg::MC_PRE;
        if (head_miss) begin
          next_pv[hit_idx] = 1'b0;
        end else begin
          // flush: an untracked page must not stay open in the memory
          next_mem.bank   = pbank[victim];
          next_mem.row    = prow[victim];
          next_pv[victim] = 1'b0;
          next_victim     = victim + lap_pkg::POOL_W'(1);
        end
        next_st = S_ACT;
      end
      S_ACT: begin
        next_mem.cmd = lap_pkg::MC_ACT;
        next_pv[free_idx]    = 1'b1;
        next_pbank[free_idx] = q[0].bank;
        next_prow[free_idx]  = q[0].row;
        next_st = S_CAS;
      end
      S_CAS: begin
        if (dcnt <= 3'h1) begin
          next_mem.cmd = q[0].is_write ? lap_pkg::MC_WRITE
                                       : lap_pkg::MC_READ;
          next_mem.auto_close_flag = head_close;
          if (head_close) begin
            for (int i = 0; i < lap_pkg::POOL_N; i++) begin
              if (pbank[i] == q[0].bank) begin
                next_pv[i] = 1'b0;
              end
            end
          end
          if (q[0].is_write) begin
            next_dcnt = lap_pkg::BURST_CYCLES;
          end
          pop     = 1'b1;
          next_st = S_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    next_qcnt = qcnt;
    next_q    = q;
    push      = req_valid_i && req_ready_o;
    if (pop) begin
      for (int i = 0; i < lap_pkg::QDEPTH - 1; i++) begin
        next_q[i] = q[i + 1];
      end
      next_qcnt = qcnt - (lap_pkg::QPTR_W + 1)'(1);
    end
    if (push) begin
      next_q[next_qcnt[lap_pkg::QPTR_W-1:0]] = req_i;
      next_qcnt = next_qcnt + (lap_pkg::QPTR_W + 1)'(1);
    end
    next_ready = (next_qcnt < (lap_pkg::QPTR_W + 1)'(lap_pkg::QDEPTH - 1));
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st                <= S_IDLE;
      dcnt              <= lap_pkg::CNT_RESET;
      qcnt              <= lap_pkg::QCNT_RESET;
      q                 <= '{default: '0};
      pv                <= '0;
      pbank             <= '{default: '0};
      prow              <= '{default: '0};
      victim            <= '0;
      mem_o             <= lap_pkg::MEM_IDLE;
      req_ready_o       <= 1'b0;
      wdata_slot_o      <= 1'b0;
      wdata_beat_pair_o <= 3'h0;
    end else begin
      st                <= next_st;
      dcnt              <= next_dcnt;
      qcnt              <= next_qcnt;
      q                 <= next_q;
      pv                <= next_pv;
      pbank             <= next_pbank;
      prow              <= next_prow;
      victim            <= next_victim;
      mem_o             <= next_mem;
      req_ready_o       <= next_ready;
      wdata_slot_o      <= next_slot;
      wdata_beat_pair_o <= next_pair;
    end
  end

endmodule

// file: lap_asserts.sv
`timescale 1ns/100ps
module lap_asserts (
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic              lookahead_en_i,
  input wire logic              user_close_en_i,
  input wire logic              req_ready_o,
  input wire lap_pkg::mem_bus_t mem_o,
  input wire logic              wdata_slot_o,
  input wire logic [2:0]        wdata_beat_pair_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire cas = mem_o.cmd == lap_pkg::MC_WRITE || mem_o.cmd == lap_pkg::MC_READ;
  sequence wr_s;
    mem_o.cmd == lap_pkg::MC_WRITE;
  endsequence
  sequence pairs_s;
    wdata_beat_pair_o == 3'h0 ##1 wdata_beat_pair_o == 3'h1
    ##1 wdata_beat_pair_o == 3'h2 ##1 wdata_beat_pair_o == 3'h3;
  endsequence
  slot_span_a: assert property (wr_s |=> wdata_slot_o [*4])
    else $error("write slot shorter than four cycles");
  pair_order_a: assert property (wr_s |=> pairs_s)
    else $error("beat pair order wrong");
  slot_cause_a: assert property ($rose(wdata_slot_o) |->
    $past(mem_o.cmd) == lap_pkg::MC_WRITE)
    else $error("slot without write");
  cas_gap_a: assert property (wr_s |=> !cas [*3])
    else $error("column command inside burst");
  pre_then_act_a: assert property (mem_o.cmd == lap_pkg::MC_PRE |=>
    ##[0:3] mem_o.cmd == lap_pkg::MC_ACT)
    else $error("precharge not followed by activate");
  act_then_cas_a: assert property (mem_o.cmd == lap_pkg::MC_ACT |=>
    ##[0:3] cas)
    else $error("activate not followed by access");
  no_close_off_a: assert property (!lookahead_en_i && !user_close_en_i
    && cas |-> !mem_o.auto_close_flag)
    else $error("auto close with features off");
  ready_start_a: assert property ($past(rst_i) |->
    mem_o.cmd == lap_pkg::MC_NOP ##1 req_ready_o)
    else $error("ready not raised after reset");
endmodule
bind lookahead_autoprecharge_ctrl lap_asserts u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .lookahead_en_i(lookahead_en_i),
  .user_close_en_i(user_close_en_i), .req_ready_o(req_ready_o),
  .mem_o(mem_o), .wdata_slot_o(wdata_slot_o),
  .wdata_beat_pair_o(wdata_beat_pair_o));

// file: sdram_model.sv
`timescale 1ns/100ps
module sdram_model (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire lap_pkg::mem_bus_t mem_o,
  output int                     errs,
  output int                     n_act,
  output int                     n_pre
);
  logic [7:0]                  open;
  logic [lap_pkg::ROW_W-1:0]   row [8];
  wire  [2:0]                  b = mem_o.bank;
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      errs <= 0; n_act <= 0; n_pre <= 0; open <= '0;
    end else begin
      case (mem_o.cmd)
        lap_pkg::MC_ACT: begin
          if (open[b]) errs <= errs + 1;
          open[b] <= 1'b1;
          row[b] <= mem_o.row;
          n_act <= n_act + 1;
        end
        lap_pkg::MC_PRE: begin
          if (!open[b]) errs <= errs + 1;
          open[b] <= 1'b0;
          n_pre <= n_pre + 1;
        end
        lap_pkg::MC_WRITE, lap_pkg::MC_READ: begin
          if (!open[b] || row[b] !== mem_o.row) errs <= errs + 1;
          if (mem_o.auto_close_flag) open[b] <= 1'b0;
        end
        default: ;
      endcase
    end
  end
endmodule

// file: test_lookahead_autoprecharge_ctrl.sv
`timescale 1ns/100ps
module test_lookahead_autoprecharge_ctrl;
  logic               mclk_i = 0, rst_i = 1, la = 0, uc = 0, vld = 0;
  lap_pkg::user_req_t req = '0;
  lap_pkg::mem_bus_t  mem;
  logic               rdy, slot;
  logic [2:0]         pair;
  int                 failures = 0, n_tests = 0, errs, n_act, n_pre;
  int                 n_slot = 0;
  always #5 mclk_i = ~mclk_i;
  // counts data slot cycles handed to the write path
  always @(posedge mclk_i) begin
    if (rst_i)
      n_slot <= 0;
    else if (slot === 1'b1)
      n_slot <= n_slot + 1;
  end
  lookahead_autoprecharge_ctrl dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .lookahead_en_i(la),
    .user_close_en_i(uc), .req_valid_i(vld), .req_i(req),
    .req_ready_o(rdy), .mem_o(mem), .wdata_slot_o(slot),
    .wdata_beat_pair_o(pair));
  sdram_model mdl (
    .mclk_i(mclk_i), .rst_i(rst_i), .mem_o(mem),
    .errs(errs), .n_act(n_act), .n_pre(n_pre));
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input int g, input int e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rst(input logic l, input logic u);
    la <= l; uc <= u; rst_i <= 1'b1;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  // holds the request until ready is seen at the taking edge
  task send(input logic w, input logic f, input logic [2:0] b,
            input logic [lap_pkg::ROW_W-1:0] r);
    logic ok;
    vld <= 1'b1;
    req <= '{is_write: w, auto_close_flag: f, bank: b, row: r, col: '0};
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      #1 ok = (rdy === 1'b1);
      @(posedge mclk_i);
    end
    if (!ok) begin
      failures++;
      report_and_stop;
    end
  endtask
  task drain(input int a, input int p, input int s);
    vld <= 1'b0;
    repeat (60) @(posedge mclk_i);
    chk(n_act, a);
    chk(n_pre, p);
    chk(errs, 0);
    chk(n_slot, s);
    $display("test done");
  endtask
  task t_plain;
    rst(1'b0, 1'b0);
    send(1, 0, 3'h0, 14'h0001);
    send(1, 0, 3'h0, 14'h0002);
    send(0, 0, 3'h0, 14'h0003);
    drain(3, 2, 8);
  endtask
  task t_look;
    rst(1'b1, 1'b0);
    send(1, 0, 3'h0, 14'h0001);
    send(1, 0, 3'h0, 14'h0002);
    drain(2, 0, 8);
  endtask
  task t_user;
    rst(1'b0, 1'b1);
    send(1, 1, 3'h3, 14'h0005);
    send(0, 0, 3'h3, 14'h0006);
    drain(2, 0, 4);
  endtask
  task t_flush;
    rst(1'b0, 1'b0);
    for (int i = 0; i < 5; i++)
      send(1, 0, 3'(i), 14'(i));
    send(1, 0, 3'h0, 14'h0000);
    vld <= 1'b0;
    repeat (80) @(posedge mclk_i);
    chk(errs, 0);
    chk(n_act, 6);
    chk(n_pre, 2);
    chk(n_slot, 24);
    $display("test done");
  endtask
  initial begin
    t_plain;
    t_look;
    t_user;
    t_flush;
    report_and_stop;
  end
endmodule
